/* File: common/mac_status_pkg.sv */
// Package with register map, field layout and carrier types of the MAC status block
package mac_status_pkg;

    localparam logic [31:0] ADDR_GENERAL_STATUS  = 32'hfff030b4;
    localparam logic [31:0] ADDR_MISSED_COUNTER  = 32'hfff030b8;
    localparam logic [31:0] ADDR_COMMAND         = 32'hfff03100;
    localparam logic [31:0] ADDR_INT_STATUS      = 32'hfff03104;
    localparam logic [31:0] ADDR_INT_ENABLE      = 32'hfff03108;

    localparam logic [31:0] GSTA_RESET           = 32'h00000000;
    localparam logic [15:0] MISSED_RESET         = 16'h7fff;

    // General status bit positions
    localparam int BIT_TX_HALTED      = 11;
    localparam int BIT_SQE            = 10;
    localparam int BIT_TX_PAUSED      = 9;
    localparam int BIT_DEFERRED       = 8;
    localparam int COLLISION_COUNT_FIELD_LSB           = 4;
    localparam int COLLISION_COUNT_FIELD_MSB           = 7;
    localparam int BIT_RX_FIFO_FULL   = 2;
    localparam int BIT_RX_HALTED      = 1;
    localparam int BIT_CTRL_FRAME     = 0;
    localparam logic [31:0] GSTA_FLAG_MASK = 32'h00000f07;

    // Command register bit positions
    localparam int CMD_RX_ENABLE      = 0;
    localparam int CMD_TX_ENABLE      = 8;
    localparam int CMD_SEND_PAUSE     = 16;
    localparam int CMD_QUALITY_CHECK  = 17;
    localparam int CMD_FULL_DUPLEX    = 20;
    localparam int CMD_SPEED_10M      = 21;
    // Send-pause is a one-cycle request and is not kept in the stored command
    localparam logic [31:0] CMD_STORE_MASK = 32'h00320101;
    localparam logic [31:0] CMD_RESET      = 32'h00000000;

    // Interrupt status bit positions
    localparam int IST_SUMMARY        = 0;
    localparam int IST_CRC_ERROR      = 1;
    localparam int IST_RX_OVERFLOW    = 2;
    localparam int IST_MISSED_OVF     = 14;
    localparam int IST_LOW            = 1;
    localparam int IST_HIGH           = 14;
    localparam logic [31:0] IST_STORE_MASK = 32'h00004006;
    localparam logic [31:0] IEN_STORE_MASK = 32'h00007ffe;

    localparam logic [3:0]  COLLISION_COUNT_FIELD_LAST      = 4'hf;
    localparam logic [2:0]  RX_FULL_PKTS   = 3'h4;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    typedef struct packed {
        logic tx_start;
        logic tx_end;
        logic sqe_detect;
        logic deferred;
        logic collision;
        logic pause_frame_rx;
    } tx_events_t;

    typedef struct packed {
        logic       frame_start;
        logic       crc_error;
        logic       fifo_overflow;
        logic       ctrl_frame;
        logic [2:0] fifo_packets;
    } rx_events_t;

    typedef struct packed {
        logic [31:0] gsta;
        logic [3:0]  collision_count_field;
        logic [15:0] missed;
        logic [31:0] cmd;
        logic [31:0] ista;
        logic [31:0] ien;
        logic        wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
        logic        abort;
        logic        drop;
        logic        pause_req;
    } state_t;

endpackage

/* File: rtl/mac_status_missed_packet_counter.sv */
// MAC general status flags and missed-packet counter behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns

module mac_status_missed_packet_counter
    import mac_status_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire tx_events_t  tx_ev,
    input  wire rx_events_t  rx_ev,
    output logic             transmit_enable_control,
    output logic             receive_enable_control,
    output logic             quality_check_enable,
    output logic             full_duplex,
    output logic             speed_10m,
    output logic             send_pause_request,
    output logic             transmit_abort_status,
    output logic             rx_packet_drop,
    output logic             receive_interrupt_summary
);

    state_t s;
    state_t next_s;

    logic        addr_take;
    logic        wr_now;
    logic [31:0] wdat;
    logic [31:0] gsta_view;
    logic [31:0] gsta_set;
    logic [31:0] gsta_clr;
    logic [31:0] ista_set;
    logic [31:0] ista_clr;
    logic        summary;
    logic        half_duplex;
    logic        fifo_full;
    logic        drop_now;
    logic        read_counter;
    logic [16:0] missed_sum;

    assign addr_take   = hsel && hready && (htrans == HTRANS_NONSEQ) && 1'b1;
    assign wr_now      = s.wr_pend;
    assign wdat        = hwdata;
    assign half_duplex = ~s.cmd[CMD_FULL_DUPLEX];
    assign fifo_full   = (rx_ev.fifo_packets >= RX_FULL_PKTS);

    // Status view: stored flags plus collision count; reserved bits stay zero
    assign gsta_view = (s.gsta & GSTA_FLAG_MASK)
                     | {24'h000000, s.collision_count_field, 4'h0};

    // Enabled interrupt status bits 1..14 form the summary
    assign summary = |(s.ista[IST_HIGH:IST_LOW] & s.ien[IST_HIGH:IST_LOW]);

    // Dropped packets: FIFO full or reception disabled at start, CRC error, overflow
    assign drop_now = (rx_ev.frame_start && (fifo_full || !s.cmd[CMD_RX_ENABLE]))
                    || rx_ev.crc_error
                    || rx_ev.fifo_overflow;

    assign read_counter = addr_take && !hwrite && (haddr == ADDR_MISSED_COUNTER);

    always_comb begin
        next_s       = s;
        gsta_set     = 32'h00000000;
        gsta_clr     = 32'h00000000;
        ista_set     = 32'h00000000;
        ista_clr     = 32'h00000000;
        missed_sum   = {1'b0, s.missed};

        next_s.abort     = 1'b0;
        next_s.drop      = drop_now;
        next_s.pause_req = 1'b0;

        // Register writes land in the data phase
        if (wr_now) begin
            case (s.wr_addr)
                ADDR_GENERAL_STATUS: begin
                    gsta_clr = wdat & GSTA_FLAG_MASK;
                end
                ADDR_MISSED_COUNTER: begin
                    missed_sum = {1'b0, wdat[15:0]};
                end
                ADDR_COMMAND: begin
                    next_s.cmd = wdat & CMD_STORE_MASK;
                    next_s.pause_req = wdat[CMD_SEND_PAUSE];
                end
                ADDR_INT_STATUS: begin
                    ista_clr = wdat & IST_STORE_MASK;
                end
                ADDR_INT_ENABLE: begin
                    next_s.ien = wdat & IEN_STORE_MASK;
                end
                default: begin
                end
            endcase
        end

        // Halted flags follow the falling edge of each enable
        if (s.cmd[CMD_TX_ENABLE] && !next_s.cmd[CMD_TX_ENABLE]) begin
            gsta_set[BIT_TX_HALTED] = 1'b1;
        end
        if (s.cmd[CMD_RX_ENABLE] && !next_s.cmd[CMD_RX_ENABLE]) begin
            gsta_set[BIT_RX_HALTED] = 1'b1;
        end
        if (tx_ev.tx_end && tx_ev.sqe_detect && s.cmd[CMD_QUALITY_CHECK]
                && s.cmd[CMD_SPEED_10M] && half_duplex) begin
            gsta_set[BIT_SQE] = 1'b1;
        end
        if (tx_ev.pause_frame_rx || next_s.pause_req) begin
            gsta_set[BIT_TX_PAUSED] = 1'b1;
        end
        if (tx_ev.deferred && half_duplex) begin
            gsta_set[BIT_DEFERRED] = 1'b1;
        end
        if (fifo_full) begin
            gsta_set[BIT_RX_FIFO_FULL] = 1'b1;
        end
        if (rx_ev.ctrl_frame && s.cmd[CMD_FULL_DUPLEX]) begin
            gsta_set[BIT_CTRL_FRAME] = 1'b1;
        end

        // Set wins over a simultaneous write-one clear
        next_s.gsta = ((s.gsta & ~gsta_clr) | gsta_set) & GSTA_FLAG_MASK;

        // Collision count: a write of ones clears, a collision counts over it
        if (wr_now && (s.wr_addr == ADDR_GENERAL_STATUS) && (|wdat[COLLISION_COUNT_FIELD_MSB:COLLISION_COUNT_FIELD_LSB])) begin
            next_s.collision_count_field = 4'h0;
        end
        if (tx_ev.tx_start) begin
            next_s.collision_count_field = 4'h0;
        end
        if (tx_ev.collision) begin
            next_s.collision_count_field = s.collision_count_field + 4'h1;
            if (s.collision_count_field == COLLISION_COUNT_FIELD_LAST) begin
                next_s.abort = 1'b1;
            end
        end

        // Read-clear happens as the read is taken; a drop in that cycle survives
        if (read_counter) begin
            missed_sum = 17'h00000;
        end
        if (drop_now) begin
            missed_sum = missed_sum + 17'h00001;
        end
        next_s.missed = missed_sum[15:0];
        if (missed_sum[16]) begin
            ista_set[IST_MISSED_OVF] = 1'b1;
        end
        if (rx_ev.crc_error) begin
            ista_set[IST_CRC_ERROR] = 1'b1;
        end
        if (rx_ev.fifo_overflow) begin
            ista_set[IST_RX_OVERFLOW] = 1'b1;
        end
        next_s.ista = ((s.ista & ~ista_clr) | ista_set) & IST_STORE_MASK;

        // Address phase: latch writes, capture read data
        next_s.wr_pend = addr_take && hwrite;
        if (addr_take) begin
            next_s.wr_addr = haddr;
        end
        next_s.rdata = 32'h00000000;
        if (addr_take && !hwrite) begin
            case (haddr)
                ADDR_GENERAL_STATUS: next_s.rdata = gsta_view;
                ADDR_MISSED_COUNTER: next_s.rdata = {16'h0000, s.missed};
                ADDR_COMMAND:        next_s.rdata = s.cmd;
                ADDR_INT_STATUS:     next_s.rdata = s.ista | {31'h0, summary};
                ADDR_INT_ENABLE:     next_s.rdata = s.ien;
                default:             next_s.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s           <= '0;
            s.gsta      <= GSTA_RESET;
            s.missed    <= MISSED_RESET;
            s.cmd       <= CMD_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata    = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    assign transmit_enable_control = s.cmd[CMD_TX_ENABLE];
    assign receive_enable_control  = s.cmd[CMD_RX_ENABLE];
    assign quality_check_enable    = s.cmd[CMD_QUALITY_CHECK];
    assign full_duplex             = s.cmd[CMD_FULL_DUPLEX];
    assign speed_10m               = s.cmd[CMD_SPEED_10M];
    assign send_pause_request      = s.pause_req;
    assign transmit_abort_status   = s.abort;
    assign rx_packet_drop          = s.drop;
    // General status never feeds the interrupt line
    assign receive_interrupt_summary = summary;

endmodule // mac_status_missed_packet_counter

/* File: bench/mac_status_checker.sv */
// Port-level assertions for the MAC status block
`timescale 1ns/1ns
module mac_status_checker
    import mac_status_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire rx_events_t  rx_ev,
    input wire logic        send_pause_request,
    input wire logic        receive_enable_control,
    input wire logic        transmit_abort_status,
    input wire logic        rx_packet_drop
);
    logic        ph_wr;
    logic        ph_rd;
    logic [31:0] ph_addr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 32'h0;
        end else begin
            ph_wr <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            ph_rd <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
            ph_addr <= haddr;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hreadyout && hresp == HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
    property p_idle_rdata; !ph_rd |-> hrdata == 32'h0; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside data phase");
    property p_gsta_rsvd;
        ph_rd && ph_addr == ADDR_GENERAL_STATUS |-> (hrdata & ~(GSTA_FLAG_MASK | 32'hf0)) == 0;
    endproperty
    a_gsta_rsvd: assert property (p_gsta_rsvd) else $error("status reserved bits set");
    property p_cnt_rsvd; ph_rd && ph_addr == ADDR_MISSED_COUNTER |-> hrdata[31:16] == 0; endproperty
    a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("counter upper bits set");
    property p_rx_en;
        ph_wr && ph_addr == ADDR_COMMAND |=> receive_enable_control == $past(hwdata[CMD_RX_ENABLE]);
    endproperty
    a_rx_en: assert property (p_rx_en) else $error("receive enable not loaded");
    property p_pause;
        ph_wr && ph_addr == ADDR_COMMAND && hwdata[CMD_SEND_PAUSE] |=> send_pause_request ##1
            !send_pause_request;
    endproperty
    a_pause: assert property (p_pause) else $error("send pause pulse wrong");
    property p_crc_drop; rx_ev.crc_error |=> rx_packet_drop; endproperty
    a_crc_drop: assert property (p_crc_drop) else $error("crc error not dropped");
    property p_full_drop; rx_ev.frame_start && rx_ev.fifo_packets >= RX_FULL_PKTS |=> rx_packet_drop;
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full fifo not dropped");
    property p_drop_cause;
        rx_packet_drop |-> $past(rx_ev.crc_error || rx_ev.fifo_overflow || (rx_ev.frame_start
            && (rx_ev.fifo_packets >= RX_FULL_PKTS || !receive_enable_control)));
    endproperty
    a_drop_cause: assert property (p_drop_cause) else $error("drop without cause");
    property p_abort_once; transmit_abort_status |=> !transmit_abort_status; endproperty
    a_abort_once: assert property (p_abort_once) else $error("abort longer than a cycle");
    c_abort: cover property (transmit_abort_status);
    c_drop: cover property (rx_packet_drop);
    c_read: cover property (ph_rd && ph_addr == ADDR_MISSED_COUNTER);
endmodule // mac_status_checker

bind mac_status_missed_packet_counter mac_status_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_ev(rx_ev),
    .send_pause_request(send_pause_request), .receive_enable_control(receive_enable_control),
    .transmit_abort_status(transmit_abort_status), .rx_packet_drop(rx_packet_drop));

/* File: bench/mac_status_missed_packet_counter_tb.sv */
// Self-checking bench for the MAC status block
`timescale 1ns/1ns
module mac_status_missed_packet_counter_tb;
    import mac_status_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    tx_events_t  tx_ev = '0;
    rx_events_t  rx_ev = '0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic        hreadyout;
    logic        abort;
    logic        irq;
    logic [4:0]  ctl;
    int          failures = 0;
    int          n_checks = 0;
    int          n_abort = 0;
    int          k;
    always #20 hclk = ~hclk;
    always @(posedge hclk) if (abort === 1'b1) n_abort++;
    mac_status_missed_packet_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .tx_ev(tx_ev),
        .rx_ev(rx_ev), .transmit_enable_control(ctl[4]), .receive_enable_control(ctl[3]),
        .quality_check_enable(ctl[2]), .full_duplex(ctl[1]), .speed_10m(ctl[0]),
        .send_pause_request(),
        .transmit_abort_status(abort), .rx_packet_drop(), .receive_interrupt_summary(irq));
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            test_done();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic ev(input tx_events_t t, input rx_events_t r);
        tx_ev <= t;
        rx_ev <= r;
        @(posedge hclk);
        tx_ev <= '0;
        rx_ev <= '0;
        @(posedge hclk);
    endtask
    task automatic irq_is(input logic exp);
        @(posedge hclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    // Command outputs change on the edge that lands the write; checked one edge later
    task automatic ctl_is(input logic [4:0] exp);
        @(posedge hclk);
        chk({27'h0, ctl}, {27'h0, exp});
    endtask
    initial begin
        #200000;
        failures++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_GENERAL_STATUS, GSTA_RESET);
        rd(ADDR_MISSED_COUNTER, {16'h0, MISSED_RESET});
        rd(ADDR_MISSED_COUNTER, 32'h0);
        wr(ADDR_INT_ENABLE, 32'h00007ffe);
        wr(ADDR_COMMAND, 32'h00000101);
        ctl_is(5'h18);
        wr(ADDR_COMMAND, 32'h00220000);
        ctl_is(5'h05);
        rd(ADDR_GENERAL_STATUS, 32'h00000802);
        ev(6'h18, 7'h00);
        ev(6'h04, 7'h00);
        ev(6'h01, 7'h00);
        ev(6'h00, 7'h0c);
        for (k = 0; k < 15; k++) begin
            ev(6'h02, 7'h00);
        end
        rd(ADDR_GENERAL_STATUS, 32'h00000ff6);
        irq_is(1'b0);
        ev(6'h02, 7'h00);
        rd(ADDR_GENERAL_STATUS, 32'h00000f06);
        chk(n_abort, 32'h1);
        wr(ADDR_GENERAL_STATUS, 32'h00000501);
        rd(ADDR_GENERAL_STATUS, 32'h00000a06);
        wr(ADDR_COMMAND, 32'h00100000);
        wr(ADDR_GENERAL_STATUS, 32'hffffffff);
        ev(6'h04, 7'h08);
        rd(ADDR_GENERAL_STATUS, 32'h00000001);
        wr(ADDR_INT_ENABLE, 32'h00004000);
        wr(ADDR_COMMAND, 32'h00100001);
        ev(6'h00, 7'h44);
        ev(6'h00, 7'h42);
        ev(6'h00, 7'h20);
        ev(6'h00, 7'h10);
        wr(ADDR_COMMAND, 32'h00100000);
        ev(6'h00, 7'h40);
        rd(ADDR_MISSED_COUNTER, 32'h00000004);
        irq_is(1'b0);
        wr(ADDR_MISSED_COUNTER, 32'habcdfffe);
        ev(6'h00, 7'h20);
        irq_is(1'b0);
        ev(6'h00, 7'h20);
        irq_is(1'b1);
        rd(ADDR_MISSED_COUNTER, 32'h0);
        rd(ADDR_INT_STATUS, 32'h00004007);
        wr(ADDR_INT_STATUS, 32'h00004006);
        irq_is(1'b0);
        wr(ADDR_MISSED_COUNTER, 32'habcd1234);
        rd(ADDR_MISSED_COUNTER, 32'h00001234);
        rd(32'hfff030bc, 32'h0);
        wr(ADDR_GENERAL_STATUS, 32'hffffffff);
        ev(6'h02, 7'h00);
        ev(6'h02, 7'h00);
        wr(ADDR_COMMAND, 32'h00110000);
        rd(ADDR_GENERAL_STATUS, 32'h00000220);
        rd(ADDR_COMMAND, 32'h00100000);
        ev(6'h20, 7'h00);
        rd(ADDR_GENERAL_STATUS, 32'h00000200);
        test_done();
    end
endmodule // mac_status_missed_packet_counter_tb
